// >>> include/pud_defs.svh
`ifndef PUD_DEFS_SVH
`define PUD_DEFS_SVH
// Function
// - Hold device in reset after power-up until supply and clock are stable.
// - Power-up timer adds fixed delay only when its enable_n bit is 0.
// - Crystal modes count 1024 oscillator cycles before the clock is released.
// - Crystal-with-PLL mode adds 2 ms lock delay after the start-up count.
// - Controller-ready delay runs in parallel with the power-up timer and start-up count.
// - External, resistor-capacitor and internal oscillator modes skip the start-up count.
// - In Sleep, clock-output modes hold the oscillator output pin low.
// - Port variants hand the oscillator output pin to port A bit 6.
// - In Sleep, crystal modes disable the feedback inverter, pins quiescent.
// - Sleep stops every clock; primary idle keeps the primary oscillator running.

// Clock rate and delay times
`define PUD_CLK_HZ 40000000
`define PUD_PLL_LOCK_US 2000
`define PUD_PLL_LOCK_CYC ((`PUD_PLL_LOCK_US * (`PUD_CLK_HZ / 1000000)))
`define PUD_STARTUP_COUNT 1024
`define PUD_PWRUP_US_DEF 65600
`define PUD_READY_US_DEF 10
`define PUD_CNT_W 32
`define PUD_STARTUP_W 11
`define PUD_PORT_BIT 6
`endif

// >>> include/pud_pkg.sv
package pud_pkg;
   // Primary oscillator configuration
   typedef enum logic [3:0] {
      PUD_XTAL_LOW = 4'h0, PUD_XTAL_STD = 4'h1, PUD_XTAL_FAST = 4'h2, PUD_XTAL_PLL = 4'h3,
      PUD_EXT = 4'h4, PUD_EXT_PORT = 4'h5, PUD_RESCAP_OSC = 4'h6, PUD_RESCAP_PORT = 4'h7,
      PUD_INT_CLKOUT = 4'h8, PUD_INT_PORT = 4'h9
   } pud_osc_mode_e;
   typedef enum logic [1:0] {
      PUD_ST_RESET = 2'b00, PUD_ST_WAIT = 2'b01, PUD_ST_RUN = 2'b10
   } pud_state_e;
   // Output pin drive group
   typedef struct packed {
      logic outVal;
      logic outEn;
      logic feedbackEn;
      logic portOwns;
   } pud_pin_s;
endpackage

// >>> hw/pud_delay_timer.sv
`timescale 1ns/1ps
`include "pud_defs.svh"
// One-shot down counter; done stays high once the load count has passed
module pud_delay_timer
   import pud_pkg::*;
#(
   parameter int unsigned W = `PUD_CNT_W
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic tick,
   input wire logic [W-1:0] loadVal,
   output logic done
);
   logic [W-1:0] cnt_ff, nxt_cnt;
   logic run_ff, nxt_run, done_ff, nxt_done;

   // --------------------------------
   // Count logic
   // --------------------------------
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_run = run_ff;
      nxt_done = done_ff;
      if (start) begin
         nxt_cnt = loadVal;
         nxt_run = 1'b1;
         nxt_done = 1'b0;
      end else if (run_ff && tick) begin
         if (cnt_ff <= W'(1)) begin
            nxt_run = 1'b0;
            nxt_done = 1'b1;
         end else begin
            nxt_cnt = cnt_ff - W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         run_ff <= nxt_run;
         done_ff <= nxt_done;
      end
   end
   assign done = done_ff;
endmodule

// >>> hw/pud_sequencer.sv
`timescale 1ns/1ps
`include "pud_defs.svh"
module pud_sequencer
   import pud_pkg::*;
#(
   parameter int unsigned PWRUP_CYC = `PUD_PWRUP_US_DEF * (`PUD_CLK_HZ / 1000000),
   parameter int unsigned READY_CYC = `PUD_READY_US_DEF * (`PUD_CLK_HZ / 1000000),
   parameter int unsigned PLL_CYC = `PUD_PLL_LOCK_CYC
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic powerOnEvent,
   input wire logic oscClkRaw,
   input wire logic [3:0] oscMode,
   input wire logic powerUpTimerEnableN,
   input wire logic sleepReq,
   input wire logic primaryIdleMode,
   input wire logic portA6Out,
   input wire logic portA6OutEn,
   input wire logic fourthClk,
   output logic internalResetN,
   output logic cpuReady,
   output logic primaryOscRun,
   output logic oscOutVal,
   output logic oscOutEn,
   output logic feedbackEn,
   output logic oscOutIsPort
);
   // --------------------------------
   // Synchronisers
   // --------------------------------
   logic [2:0] porSync_ff, nxt_porSync;
   logic [2:0] oscSync_ff, nxt_oscSync;
   logic porStable_ff, nxt_porStable;
   logic oscStable_ff, nxt_oscStable;

   // Three stages; a change counts once the last two agree
   always_comb begin
      nxt_porSync = {porSync_ff[1:0], powerOnEvent};
      nxt_oscSync = {oscSync_ff[1:0], oscClkRaw};
      nxt_porStable = (porSync_ff[2] == porSync_ff[1]) ? porSync_ff[2] : porStable_ff;
      nxt_oscStable = (oscSync_ff[2] == oscSync_ff[1]) ? oscSync_ff[2] : oscStable_ff;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         porSync_ff <= 3'h0;
         oscSync_ff <= 3'h0;
         porStable_ff <= 1'b0;
         oscStable_ff <= 1'b0;
      end else begin
         porSync_ff <= nxt_porSync;
         oscSync_ff <= nxt_oscSync;
         porStable_ff <= nxt_porStable;
         oscStable_ff <= nxt_oscStable;
      end
   end

   // --------------------------------
   // Mode decode
   // --------------------------------
   pud_osc_mode_e mode;
   logic isCrystal, isPll, isPortMode, isClkOut;
   assign mode = pud_osc_mode_e'(oscMode);
   // Unused codes fall through every group and leave the pin idle
   always_comb begin
      isCrystal = (mode == PUD_XTAL_LOW) || (mode == PUD_XTAL_STD) ||
                  (mode == PUD_XTAL_FAST) || (mode == PUD_XTAL_PLL);
      isPll = (mode == PUD_XTAL_PLL);
      isPortMode = (mode == PUD_EXT_PORT) || (mode == PUD_RESCAP_PORT) ||
                   (mode == PUD_INT_PORT);
      isClkOut = (mode == PUD_EXT) || (mode == PUD_RESCAP_OSC) ||
                 (mode == PUD_INT_CLKOUT);
   end

   // --------------------------------
   // Sequencer state
   // --------------------------------
   pud_state_e state_ff, nxt_state;
   logic [`PUD_STARTUP_W-1:0] startCnt_ff, nxt_startCnt;
   logic oscPrev_ff, nxt_oscPrev;
   logic startDone_ff, nxt_startDone;
   logic pwrUpEn_ff, nxt_pwrUpEn;
   logic startAll, pllStart, pwrUpDone, readyDone, pllDone, oscEdge;

   // Sequence starts once the synced supply flag has settled high
   assign startAll = (state_ff == PUD_ST_RESET) && porStable_ff;
   assign oscEdge = oscStable_ff && !oscPrev_ff;
   // PLL lock wait opens only as the start-up count ends
   assign pllStart = isPll && (state_ff == PUD_ST_WAIT) && !startDone_ff &&
                     (nxt_startDone);

   always_comb begin
      nxt_state = state_ff;
      nxt_startCnt = startCnt_ff;
      nxt_oscPrev = oscStable_ff;
      nxt_startDone = startDone_ff;
      nxt_pwrUpEn = pwrUpEn_ff;
      case (state_ff)
         PUD_ST_RESET: begin
            if (porStable_ff) begin
               nxt_state = PUD_ST_WAIT;
               nxt_startCnt = '0;
               nxt_pwrUpEn = !powerUpTimerEnableN;
               nxt_startDone = !isCrystal;
            end
         end
         PUD_ST_WAIT: begin
            // Raw clock must stay below a quarter of clk so each level is seen twice
            if (!startDone_ff && oscEdge) begin
               if (startCnt_ff == `PUD_STARTUP_W'(`PUD_STARTUP_COUNT - 1)) begin
                  nxt_startDone = 1'b1;
               end else begin
                  nxt_startCnt = startCnt_ff + `PUD_STARTUP_W'h1;
               end
            end
            // Power-up, ready and start-up waits run together, PLL lock after start-up; the longest decides
            if (startDone_ff && readyDone && (pwrUpDone || !pwrUpEn_ff) &&
                (pllDone || !isPll)) begin
               nxt_state = PUD_ST_RUN;
            end
         end
         PUD_ST_RUN: begin
            nxt_state = PUD_ST_RUN;
         end
         default: begin
            nxt_state = PUD_ST_RESET;
         end
      endcase
      // A fresh power-on event starts everything over
      if (!porStable_ff) begin
         nxt_state = PUD_ST_RESET;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= PUD_ST_RESET;
         startCnt_ff <= '0;
         oscPrev_ff <= 1'b0;
         startDone_ff <= 1'b0;
         pwrUpEn_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         startCnt_ff <= nxt_startCnt;
         oscPrev_ff <= nxt_oscPrev;
         startDone_ff <= nxt_startDone;
         pwrUpEn_ff <= nxt_pwrUpEn;
      end
   end

   // --------------------------------
   // Delay timers
   // --------------------------------
   // Fixed power-up wait; never loaded when its enable_n input is high
   pud_delay_timer uPwrUp (
      .clk(clk),
      .resetn(resetn),
      .start(startAll && !powerUpTimerEnableN),
      .tick(1'b1),
      .loadVal(`PUD_CNT_W'(PWRUP_CYC)),
      .done(pwrUpDone)
   );
   // Ready wait loads with the power-up wait and start-up count, so it overlaps rather than adds
   pud_delay_timer uReady (
      .clk(clk),
      .resetn(resetn),
      .start(startAll),
      .tick(1'b1),
      .loadVal(`PUD_CNT_W'(READY_CYC)),
      .done(readyDone)
   );
   // Lock wait follows the start-up count instead of overlapping it
   pud_delay_timer uPll (
      .clk(clk),
      .resetn(resetn),
      .start(pllStart),
      .tick(1'b1),
      .loadVal(`PUD_CNT_W'(PLL_CYC)),
      .done(pllDone)
   );

   // --------------------------------
   // Outputs
   // --------------------------------
   pud_pin_s pin_ff, nxt_pin;
   logic rstN_ff, nxt_rstN, oscRun_ff, nxt_oscRun;

   // Reset stays asserted until the run state; no external circuit needed
   always_comb begin
      nxt_rstN = (nxt_state == PUD_ST_RUN);
      // Sleep stops all clocks unless primary idle keeps the primary alive
      nxt_oscRun = !sleepReq || primaryIdleMode;
      nxt_pin = '{outVal: 1'b0, outEn: 1'b0, feedbackEn: 1'b0, portOwns: 1'b0};
      if (isPortMode) begin
         nxt_pin.portOwns = 1'b1;
         nxt_pin.outVal = portA6Out;
         nxt_pin.outEn = portA6OutEn;
      end else if (isClkOut) begin
         nxt_pin.outEn = 1'b1;
         nxt_pin.outVal = (sleepReq && !primaryIdleMode) ? 1'b0 : fourthClk;
      end else if (isCrystal) begin
         nxt_pin.feedbackEn = !(sleepReq && !primaryIdleMode);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstN_ff <= 1'b0;
         oscRun_ff <= 1'b0;
         pin_ff <= '0;
      end else begin
         rstN_ff <= nxt_rstN;
         oscRun_ff <= nxt_oscRun;
         pin_ff <= nxt_pin;
      end
   end

   assign internalResetN = rstN_ff;
   assign cpuReady = rstN_ff && readyDone;
   assign primaryOscRun = oscRun_ff;
   assign oscOutVal = pin_ff.outVal;
   assign oscOutEn = pin_ff.outEn;
   assign feedbackEn = pin_ff.feedbackEn;
   assign oscOutIsPort = pin_ff.portOwns;
endmodule

// >>> verif/pud_sequencer_sva.sv
`timescale 1ns/1ps
module pud_sequencer_chk
   import pud_pkg::*;
#(
   parameter int unsigned PWRUP_CYC = 50,
   parameter int unsigned READY_CYC = 20
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic powerOnEvent,
   input wire logic oscClkRaw,
   input wire logic [3:0] oscMode,
   input wire logic powerUpTimerEnableN,
   input wire logic sleepReq,
   input wire logic primaryIdleMode,
   input wire logic portA6Out,
   input wire logic internalResetN,
   input wire logic cpuReady,
   input wire logic primaryOscRun,
   input wire logic oscOutVal,
   input wire logic oscOutEn,
   input wire logic feedbackEn,
   input wire logic oscOutIsPort
);
   // ---
   // Helpers
   // ---
   logic [15:0] porCnt_ff, nxt_porCnt, edgeCnt_ff, nxt_edgeCnt;
   logic oscQ_ff, nxt_oscQ, slp;
   assign slp = sleepReq && !primaryIdleMode;
   // Raw edges lead the synced ones, so this count is an upper bound
   always_comb begin
      nxt_oscQ = oscClkRaw;
      nxt_porCnt = powerOnEvent ? porCnt_ff + 16'h0001 : 16'h0000;
      nxt_edgeCnt = powerOnEvent ? edgeCnt_ff + {15'h0000, oscClkRaw & !oscQ_ff} : 16'h0000;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         porCnt_ff <= 16'h0000;
         edgeCnt_ff <= 16'h0000;
         oscQ_ff <= 1'b0;
      end else begin
         porCnt_ff <= nxt_porCnt;
         edgeCnt_ff <= nxt_edgeCnt;
         oscQ_ff <= nxt_oscQ;
      end
   end
   // ---
   // Assertions
   // ---
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_supply_loss_hold: assert property (!powerOnEvent [*6] |-> !internalResetN)
      else $error("reset released without supply");
   a_pwrup_wait: assert property ($rose(internalResetN) && !powerUpTimerEnableN
      |-> porCnt_ff >= PWRUP_CYC) else $error("power-up timer cut short");
   a_ready_wait: assert property ($rose(internalResetN) |-> porCnt_ff >= READY_CYC)
      else $error("ready delay cut short");
   a_startup_count: assert property ($rose(internalResetN) && oscMode < 4'h4
      |-> edgeCnt_ff >= 16'h0400) else $error("start-up count cut short");
   a_ready_gated: assert property (cpuReady == internalResetN)
      else $error("cpu ready differs from reset release");
   a_sleep_stops: assert property (slp |=> !primaryOscRun)
      else $error("oscillator runs in sleep");
   a_clkout_low: assert property (slp && oscMode inside {4'h4, 4'h6, 4'h8}
      |=> oscOutEn && !oscOutVal) else $error("clock output not low in sleep");
   a_port_pass: assert property (oscMode inside {4'h5, 4'h7, 4'h9}
      |=> oscOutIsPort && oscOutVal == $past(portA6Out)) else $error("port bit not on pin");
   a_xtal_quiet: assert property (slp && oscMode < 4'h4 |=> !feedbackEn && !oscOutEn)
      else $error("inverter active in sleep");
endmodule

bind pud_sequencer pud_sequencer_chk #(.PWRUP_CYC(PWRUP_CYC), .READY_CYC(READY_CYC)) i_chk (
   .clk(clk), .resetn(resetn), .powerOnEvent(powerOnEvent), .oscClkRaw(oscClkRaw),
   .oscMode(oscMode), .powerUpTimerEnableN(powerUpTimerEnableN), .sleepReq(sleepReq),
   .primaryIdleMode(primaryIdleMode), .portA6Out(portA6Out), .internalResetN(internalResetN),
   .cpuReady(cpuReady), .primaryOscRun(primaryOscRun), .oscOutVal(oscOutVal),
   .oscOutEn(oscOutEn), .feedbackEn(feedbackEn), .oscOutIsPort(oscOutIsPort));

// >>> verif/pud_osc_model.sv
`timescale 1ns/1ps
// Crystal source, 5 MHz, phase unrelated to clk
module pud_osc_model (
   input wire logic run,
   output logic oscClkRaw
);
   // Stopped source sits low, as in Sleep
   initial begin
      oscClkRaw = 1'b0;
      #7;
      forever begin
         #100;
         oscClkRaw = run ? !oscClkRaw : 1'b0;
      end
   end
endmodule

// >>> verif/pud_sequencer_tb_top.sv
`timescale 1ns/1ps
module pud_sequencer_tb_top;
   logic clk = 1'b0;
   logic resetn, powerOnEvent, oscRun, oscClkRaw, powerUpTimerEnableN, sleepReq;
   logic primaryIdleMode, portA6Out, portA6OutEn, fourthClk;
   logic [3:0] oscMode;
   logic internalResetN, cpuReady, primaryOscRun, oscOutVal, oscOutEn, feedbackEn, oscOutIsPort;
   int fail_count = 0;
   int checked = 0;
   always #12.5 clk = !clk;
   pud_sequencer #(.PWRUP_CYC(50), .READY_CYC(20), .PLL_CYC(30)) i_pud_sequencer (
      .clk(clk), .resetn(resetn), .powerOnEvent(powerOnEvent), .oscClkRaw(oscClkRaw),
      .oscMode(oscMode), .powerUpTimerEnableN(powerUpTimerEnableN), .sleepReq(sleepReq),
      .primaryIdleMode(primaryIdleMode), .portA6Out(portA6Out), .portA6OutEn(portA6OutEn),
      .fourthClk(fourthClk), .internalResetN(internalResetN), .cpuReady(cpuReady),
      .primaryOscRun(primaryOscRun), .oscOutVal(oscOutVal), .oscOutEn(oscOutEn),
      .feedbackEn(feedbackEn), .oscOutIsPort(oscOutIsPort));
   pud_osc_model i_pud_osc_model (.run(oscRun), .oscClkRaw(oscClkRaw));
   // ---
   // Tasks
   // ---
   task automatic check(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Supply off for 8 cycles, then on; time the release of reset
   task automatic power_up(input logic [3:0] m, input logic enN, input int lo, input int hi);
      int n;
      n = 0;
      powerOnEvent = 1'b0;
      oscMode = m;
      powerUpTimerEnableN = enN;
      repeat (8) @(negedge clk);
      powerOnEvent = 1'b1;
      while (internalResetN !== 1'b1 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      check(n >= lo && n <= hi, "release time");
      check(cpuReady === (hi < 9000), "cpu ready state");
      $display("mode %0d released after %0d cycles", m, n);
   endtask
   // Crystal mode without oscillation must stay in reset
   task automatic no_osc();
      oscRun = 1'b0;
      power_up(4'h1, 1'b1, 9000, 9000);
      check(internalResetN === 1'b0, "released without crystal");
      $display("no-oscillator test done");
   endtask
   // Pin states in Sleep, then primary idle
   task automatic sleep_pins(input logic [3:0] m);
      portA6Out = !portA6Out;
      sleepReq = 1'b1;
      repeat (3) @(negedge clk);
      check(primaryOscRun === 1'b0, "oscillator not stopped");
      if (m < 4'h4) begin
         check(feedbackEn === 1'b0 && oscOutEn === 1'b0, "inverter on");
      end else if (m[0]) begin
         check(oscOutIsPort === 1'b1 && oscOutVal === portA6Out, "port");
         check(oscOutEn === portA6OutEn, "port enable");
      end else begin
         check(oscOutEn === 1'b1 && oscOutVal === 1'b0, "clock out high");
      end
      primaryIdleMode = 1'b1;
      repeat (3) @(negedge clk);
      check(primaryOscRun === 1'b1, "idle stopped oscillator");
      if (m < 4'h4) check(feedbackEn === 1'b1, "inverter off in idle");
      else if (!m[0]) check(oscOutVal === fourthClk, "clock out lost in idle");
      sleepReq = 1'b0;
      primaryIdleMode = 1'b0;
      $display("sleep pins mode %0d done", m);
   endtask
   // ---
   // Main sequence and watchdog
   // ---
   initial begin
      resetn = 1'b0;
      powerOnEvent = 1'b0;
      oscRun = 1'b1;
      oscMode = 4'h4;
      powerUpTimerEnableN = 1'b1;
      sleepReq = 1'b0;
      primaryIdleMode = 1'b0;
      portA6Out = 1'b0;
      portA6OutEn = 1'b1;
      fourthClk = 1'b1;
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      no_osc();
      // Crystal counts 1024 edges of 8 cycles; others need no oscillator
      for (int m = 0; m < 10; m++) begin
         oscRun = (m < 4);
         if (m < 4) begin
            power_up(m[3:0], 1'b0, (m == 3) ? 8214 : 8184, (m == 3) ? 8245 : 8215);
         end else begin
            power_up(m[3:0], m[1], m[1] ? 20 : 50, m[1] ? 30 : 60);
         end
         sleep_pins(m[3:0]);
      end
      conclude();
   end
   initial begin
      #(25 * 60000);
      fail_count++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      conclude();
   end
endmodule
